// ==== shared/prm_map.svh ====
`ifndef PRM_MAP_SVH
`define PRM_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PRM_OFF_CLK_CTRL 8'h00
`define PRM_OFF_RST_CAUSE 8'h04
`define PRM_OFF_MODE 8'h08
`define PRM_OFF_IRQ_CTRL 8'h0c
`define PRM_OFF_PORT_DATA 8'h10
`define PRM_OFF_PORT_DIR 8'h14
`define PRM_OFF_PULL_EN 8'h18
`define PRM_OFF_DBG_CTRL 8'h1c
`define PRM_OFF_DBG_STAT 8'h20
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PRM_CLK_RANGE_BIT 0
`define PRM_CLK_STOP_SELF_BIT 1
`define PRM_CLK_EXT_BIT 2
`define PRM_IRQ_EN_BIT 0
`define PRM_IRQ_RISE_BIT 1
`define PRM_IRQ_PULL_BIT 2
`define PRM_DBG_VAL_BIT 0
`define PRM_DBG_START_BIT 1
`define PRM_DBG_DIV_LSB 8
`define PRM_STAT_BUSY_BIT 0
`define PRM_STAT_RX_BIT 1
`define PRM_MODE_BGND_BIT 0
`define PRM_MODE_RUN_BIT 1
`define PRM_CAUSE_POR 0
`define PRM_CAUSE_PIN 1
`define PRM_CAUSE_INT_LSB 2
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define PRM_CLK_CTRL_RST 3'h0
`define PRM_IRQ_CTRL_RST 3'h0
`define PRM_RST_PULSE_LAST 6'h21
`define PRM_BIT_LAST 4'hf
`define PRM_BIT_LOW_ONE 4'h4
`define PRM_BIT_LOW_ZERO 4'hd
`define PRM_BIT_SAMPLE 4'ha
`define PRM_RESET_VECTOR 16'hfffe
`define PRM_RESP_OKAY 2'h0
`define PRM_RESP_SLVERR 2'h2
`endif

// ==== shared/prm_pkg.sv ====
package prm_pkg;
    typedef enum logic {PRM_SRC_SELF, PRM_SRC_EXT} prm_clk_src_t;
    typedef enum logic {PRM_MODE_RUN, PRM_MODE_BGND} prm_mode_t;
endpackage

// ==== test/prm_host_model.sv ====
`timescale 1ns/1ps
// --------------------------------
// Debug host and reset source
// --------------------------------
module prm_host_model (
    input wire logic hold_dbg_low,
    input wire logic pull_rst_low,
    input wire logic dbg_pin_o,
    input wire logic dbg_pin_oe,
    input wire logic reset_pin_o,
    input wire logic reset_pin_oe,
    output logic dbg_line,
    output logic rst_line
);
    // Pulled-up lines, any low driver wins
    assign dbg_line = !(hold_dbg_low || (dbg_pin_oe && !dbg_pin_o));
    assign rst_line = !(pull_rst_low || (reset_pin_oe && !reset_pin_o));
endmodule

// ==== test/prm_top_bench.sv ====
`timescale 1ns/1ps
`include "prm_map.svh"
module prm_top_bench;
    // --------------------------------
    // Signals
    // --------------------------------
    logic clk = 1'b0, reset_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, stop_exit_i = 1'b0, irq_pin_i = 1'b0;
    logic hold_dbg_low = 1'b0, pull_rst_low = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0] s_axi_wstrb = 4'hf, int_rst_src_i = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dbg_pullup_o;
    logic reset_pin_i, reset_pin_o, reset_pin_oe, chip_rst_n_o, osc_range_hi_o, vector_fetch_o;
    logic dbg_pin_i, dbg_pin_o, dbg_pin_oe, irq_req_o, irq_level_o, irq_pull_up_o, irq_pull_down_o;
    logic [15:0] vector_addr_o;
    prm_pkg::prm_clk_src_t clk_src_o;
    prm_pkg::prm_mode_t mode_o;
    logic [7:0] pin_i = 8'h3c, pin_o, pin_oe, pull_up_o, pull_down_o, keypad_rise_i = 8'h00;
    logic [7:0] alt1_en_i = 8'h00, alt1_oe_i = 8'h00, alt1_out_i = 8'h00, alt2_en_i = 8'h00;
    logic [7:0] alt2_oe_i = 8'h00, alt2_out_i = 8'h00;
    int failures = 0, num_checks = 0, cyc = 0, lo = 0, hi = 0;
    prm_top #(.N(8), .KEYPAD_MASK(8'h80)) u_prm_top (.clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .reset_pin_i, .reset_pin_o, .reset_pin_oe, .int_rst_src_i,
        .chip_rst_n_o, .stop_exit_i, .clk_src_o, .osc_range_hi_o, .dbg_pin_i, .dbg_pin_o, .dbg_pin_oe,
        .dbg_pullup_o, .mode_o, .vector_fetch_o, .vector_addr_o, .irq_pin_i, .irq_req_o, .irq_level_o,
        .irq_pull_up_o, .irq_pull_down_o, .pin_i, .pin_o, .pin_oe, .pull_up_o, .pull_down_o, .alt1_en_i,
        .alt1_oe_i, .alt1_out_i, .alt2_en_i, .alt2_oe_i, .alt2_out_i, .keypad_rise_i);
    prm_host_model u_prm_host_model (.hold_dbg_low, .pull_rst_low, .dbg_pin_o, .dbg_pin_oe, .reset_pin_o,
        .reset_pin_oe, .dbg_line(dbg_pin_i), .rst_line(reset_pin_i));
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        lo += (dbg_pin_oe === 1'b1 && dbg_pin_o === 1'b0);
        hi += (dbg_pin_oe === 1'b1 && dbg_pin_o === 1'b1);
        if (cyc == 20000)
        begin
            failures++;
            print_verdict;
        end
    end
    // --------------------------------
    // Tasks
    // --------------------------------
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task axr(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task wait_chip;
        while (chip_rst_n_o !== 1'b1) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask
    task t_reset;
        int n;
        n = 0;
        while (reset_pin_oe !== 1'b1) @(posedge clk);
        chk(clk_src_o, prm_pkg::PRM_SRC_SELF);
        while (reset_pin_oe === 1'b1)
        begin
            n++;
            @(posedge clk);
        end
        chk(n, 34);
        while (chip_rst_n_o !== 1'b1) @(posedge clk);
        @(posedge clk);
        chk(vector_fetch_o, 1'b1);
        wait_chip;
        chk(mode_o, prm_pkg::PRM_MODE_RUN);
        chk(vector_addr_o, `PRM_RESET_VECTOR);
        chk({pin_oe, pull_up_o}, 16'h0000);
        axr(`PRM_OFF_RST_CAUSE);
        chk(rd, 32'h1);
        $display("reset test done");
    endtask
    task t_clk;
        axw(`PRM_OFF_CLK_CTRL, 32'h7);
        chk(rr, `PRM_RESP_OKAY);
        @(posedge clk);
        chk(osc_range_hi_o, 1'b1);
        chk(clk_src_o, prm_pkg::PRM_SRC_EXT);
        stop_exit_i <= 1'b1;
        @(posedge clk);
        stop_exit_i <= 1'b0;
        repeat (2) @(posedge clk);
        chk(clk_src_o, prm_pkg::PRM_SRC_SELF);
        axr(8'h40);
        chk(rr, `PRM_RESP_SLVERR);
        chk(rd, 32'h0);
        axw(8'h40, 32'h1);
        chk(rr, `PRM_RESP_SLVERR);
        $display("clock test done");
    endtask
    task t_irq;
        int n;
        n = 0;
        chk(irq_level_o, 1'b1);
        axw(`PRM_OFF_IRQ_CTRL, 32'h7);
        @(posedge clk);
        chk({irq_level_o, irq_pull_up_o, irq_pull_down_o}, 3'b001);
        irq_pin_i <= 1'b1;
        repeat (6)
        begin
            @(posedge clk);
            n += (irq_req_o === 1'b1);
        end
        chk(n, 1);
        axw(`PRM_OFF_IRQ_CTRL, 32'h5);
        chk(irq_pull_up_o, 1'b1);
        irq_pin_i <= 1'b0;
        repeat (6) @(posedge clk) n += (irq_req_o === 1'b1);
        chk(n, 2);
        $display("interrupt pin test done");
    endtask
    task t_port;
        alt1_en_i <= 8'h80;
        alt1_oe_i <= 8'h80;
        alt2_en_i <= 8'h80;
        keypad_rise_i <= 8'h80;
        axw(`PRM_OFF_PORT_DIR, 32'h0f);
        axw(`PRM_OFF_PORT_DATA, 32'ha5);
        axw(`PRM_OFF_PULL_EN, 32'hff);
        @(posedge clk);
        chk({pin_oe, pin_o[3:0]}, 12'h0f5);
        chk({pull_up_o, pull_down_o}, 16'h7080);
        axr(`PRM_OFF_PORT_DATA);
        chk(rd, 32'h35);
        {alt1_en_i, alt2_en_i} <= 16'h0000;
        $display("port test done");
    endtask
    task automatic t_dbg;
        logic [31:0] c[3] = '{32'h3, 32'h103, 32'h2};
        int lo_exp[3] = '{4, 8, 13};
        int hi_exp[3] = '{1, 2, 1};
        for (int i = 0; i < 3; i++)
        begin
            lo = 0;
            hi = 0;
            axw(`PRM_OFF_DBG_CTRL, c[i]);
            repeat (80) @(posedge clk);
            chk(lo, lo_exp[i]);
            chk(hi, hi_exp[i]);
            axr(`PRM_OFF_DBG_STAT);
            chk(rd[1:0], {c[i][0], 1'b0});
        end
        chk(dbg_pullup_o, 1'b1);
        $display("debug pin test done");
    endtask
    task t_pin;
        hold_dbg_low <= 1'b1;
        pull_rst_low <= 1'b1;
        repeat (5) @(posedge clk);
        pull_rst_low <= 1'b0;
        @(posedge clk);
        wait_chip;
        hold_dbg_low <= 1'b0;
        chk(mode_o, prm_pkg::PRM_MODE_BGND);
        axr(`PRM_OFF_RST_CAUSE);
        chk(rd, 32'h2);
        int_rst_src_i <= 4'h2;
        @(posedge clk);
        int_rst_src_i <= 4'h0;
        repeat (3) @(posedge clk);
        wait_chip;
        chk(mode_o, prm_pkg::PRM_MODE_RUN);
        axr(`PRM_OFF_RST_CAUSE);
        chk(rd, 32'h8);
        $display("pin reset test done");
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        t_reset;
        t_clk;
        t_irq;
        t_port;
        t_dbg;
        t_pin;
        print_verdict;
    end
endmodule

// ==== verilog/prm_top.sv ====
// Operation
// [R01] Self clock selected throughout reset
// [R02] Stop exit may force self clock
// [R03] Range bit picks oscillator frequency range
// [R04] Any reset drives pin low 34 cycles
// [R05] Reset cause logged in cause register
// [R06] External low on reset pin resets
// [R07] Debug pin is mode input during reset
// [R08] High at release selects run mode
// [R09] Low at release selects background mode
// [R10] Each debug bit lasts 16 clocks
// [R11] Debug bit clock scales with divider
// [R12] Debug pin open drain with speedup pulse
// [R13] Disabled interrupt pin has no effect
// [R14] Ports reset to inputs, pulls off
// [R15] Peripheral owns enable; direction selects read
// [R16] Pull enable acts whenever pin inputs
// [R17] Keypad rising sensitivity uses pull-downs
// [R18] Rising interrupt edge uses pull-down
// [R19] Highest priority enabled function owns pin
// [R20] Software clears flags before enabling interrupts
// [R21] Software disables sharers before enabling another
// [R22] Run mode fetches top reset vector
`timescale 1ns/1ps
`include "prm_map.svh"
module prm_top #(
    parameter int N = 8,
    parameter logic [N-1:0] KEYPAD_MASK = '0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic reset_pin_i,
    output logic reset_pin_o,
    output logic reset_pin_oe,
    input wire logic [3:0] int_rst_src_i,
    output logic chip_rst_n_o,
    input wire logic stop_exit_i,
    output prm_pkg::prm_clk_src_t clk_src_o,
    output logic osc_range_hi_o,
    input wire logic dbg_pin_i,
    output logic dbg_pin_o,
    output logic dbg_pin_oe,
    output logic dbg_pullup_o,
    output prm_pkg::prm_mode_t mode_o,
    output logic vector_fetch_o,
    output logic [15:0] vector_addr_o,
    input wire logic irq_pin_i,
    output logic irq_req_o,
    output logic irq_level_o,
    output logic irq_pull_up_o,
    output logic irq_pull_down_o,
    input wire logic [N-1:0] pin_i,
    output logic [N-1:0] pin_o,
    output logic [N-1:0] pin_oe,
    output logic [N-1:0] pull_up_o,
    output logic [N-1:0] pull_down_o,
    input wire logic [N-1:0] alt1_en_i,
    input wire logic [N-1:0] alt1_oe_i,
    input wire logic [N-1:0] alt1_out_i,
    input wire logic [N-1:0] alt2_en_i,
    input wire logic [N-1:0] alt2_oe_i,
    input wire logic [N-1:0] alt2_out_i,
    input wire logic [N-1:0] keypad_rise_i
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_ff1_q;
    logic rst_n_q;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_ff1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_ff1_q <= 1'b1;
            rst_n_q <= rst_ff1_q;
        end
    end

    // ----------------------------------------
    // Reset pulse and cause
    // ----------------------------------------
    logic por_pend_q;
    logic rst_drive_q;
    logic [5:0] pulse_cnt_q;
    logic pin_prev_q;
    logic [5:0] cause_q;
    logic in_rst_q;
    logic ext_fall;
    logic pulse_start;
    logic in_rst;
    logic rst_release;
    assign ext_fall = !reset_pin_i && pin_prev_q && !rst_drive_q; // [R06]
    assign pulse_start = !rst_drive_q && (por_pend_q || (|int_rst_src_i) || ext_fall);
    assign in_rst = por_pend_q || rst_drive_q || !reset_pin_i; // [R06]
    assign rst_release = in_rst_q && !in_rst;
    assign chip_rst_n_o = !in_rst;
    assign reset_pin_o = 1'b0;
    assign reset_pin_oe = rst_drive_q;

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            por_pend_q <= 1'b1;
            rst_drive_q <= 1'b0;
            pulse_cnt_q <= 6'h00;
            pin_prev_q <= 1'b1;
            in_rst_q <= 1'b1;
        end
        else
        begin
            in_rst_q <= in_rst;
            pin_prev_q <= rst_drive_q ? 1'b1 : reset_pin_i;
            if (pulse_start)
            begin
                por_pend_q <= 1'b0;
                rst_drive_q <= 1'b1; // [R04]
                pulse_cnt_q <= 6'h00;
            end
            else if (rst_drive_q)
            begin
                pulse_cnt_q <= pulse_cnt_q + 6'h01;
                if (pulse_cnt_q == `PRM_RST_PULSE_LAST)
                begin
                    rst_drive_q <= 1'b0; // [R04]
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            cause_q <= 6'h00;
        end
        else if (pulse_start)
        begin
            if (por_pend_q)
            begin
                cause_q <= 6'h01 << `PRM_CAUSE_POR; // [R05]
            end
            else if (|int_rst_src_i)
            begin
                cause_q <= {int_rst_src_i, 2'h0}; // [R05]
            end
            else
            begin
                cause_q <= 6'h01 << `PRM_CAUSE_PIN; // [R05]
            end
        end
    end

    // ----------------------------------------
    // Mode select and reset vector
    // ----------------------------------------
    logic bgnd_q;
    logic fetch_q;
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            bgnd_q <= 1'b0;
            fetch_q <= 1'b0;
            vector_addr_o <= 16'h0000;
        end
        else
        begin
            fetch_q <= rst_release && dbg_pin_i; // [R22]
            if (rst_release)
            begin
                bgnd_q <= !dbg_pin_i; // [R07] [R08] [R09]
                vector_addr_o <= `PRM_RESET_VECTOR; // [R22]
            end
        end
    end
    assign mode_o = bgnd_q ? prm_pkg::PRM_MODE_BGND : prm_pkg::PRM_MODE_RUN;
    assign vector_fetch_o = fetch_q;

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_en;
    logic [31:0] wmask;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_mux;
    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign wr_en = aw_hold_q && w_hold_q && !bvalid_q;
    assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    function automatic logic hit(input logic [7:0] a);
        hit = (a == `PRM_OFF_CLK_CTRL) || (a == `PRM_OFF_RST_CAUSE) || (a == `PRM_OFF_MODE)
            || (a == `PRM_OFF_IRQ_CTRL) || (a == `PRM_OFF_PORT_DATA) || (a == `PRM_OFF_PORT_DIR)
            || (a == `PRM_OFF_PULL_EN) || (a == `PRM_OFF_DBG_CTRL) || (a == `PRM_OFF_DBG_STAT);
    endfunction
    assign wr_hit = hit(awaddr_q);
    assign rd_hit = hit(s_axi_araddr);

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `PRM_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_en)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `PRM_RESP_OKAY : `PRM_RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    logic [2:0] clk_ctrl_q;
    logic [2:0] irq_ctrl_q;
    logic [N-1:0] data_q;
    logic [N-1:0] dir_q;
    logic [N-1:0] pull_q;
    logic [7:0] dbg_div_q;
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            clk_ctrl_q <= `PRM_CLK_CTRL_RST;
            irq_ctrl_q <= `PRM_IRQ_CTRL_RST;
            data_q <= '0;
            dir_q <= '0;
            pull_q <= '0;
            dbg_div_q <= 8'h00;
        end
        else if (in_rst)
        begin
            clk_ctrl_q <= `PRM_CLK_CTRL_RST;
            irq_ctrl_q <= `PRM_IRQ_CTRL_RST;
            data_q <= '0;
            dir_q <= '0; // [R14]
            pull_q <= '0; // [R14]
            dbg_div_q <= 8'h00;
        end
        else
        begin
            if (wr_en && awaddr_q == `PRM_OFF_CLK_CTRL)
            begin
                clk_ctrl_q <= (clk_ctrl_q & ~wmask[2:0]) | (wdata_q[2:0] & wmask[2:0]); // [R03]
            end
            else if (stop_exit_i && clk_ctrl_q[`PRM_CLK_STOP_SELF_BIT])
            begin
                clk_ctrl_q[`PRM_CLK_EXT_BIT] <= 1'b0; // [R02]
            end
            if (wr_en && awaddr_q == `PRM_OFF_IRQ_CTRL)
            begin
                irq_ctrl_q <= (irq_ctrl_q & ~wmask[2:0]) | (wdata_q[2:0] & wmask[2:0]);
            end
            if (wr_en && awaddr_q == `PRM_OFF_PORT_DATA)
            begin
                data_q <= (data_q & ~wmask[N-1:0]) | (wdata_q[N-1:0] & wmask[N-1:0]);
            end
            if (wr_en && awaddr_q == `PRM_OFF_PORT_DIR)
            begin
                dir_q <= (dir_q & ~wmask[N-1:0]) | (wdata_q[N-1:0] & wmask[N-1:0]);
            end
            if (wr_en && awaddr_q == `PRM_OFF_PULL_EN)
            begin
                pull_q <= (pull_q & ~wmask[N-1:0]) | (wdata_q[N-1:0] & wmask[N-1:0]);
            end
            if (wr_en && awaddr_q == `PRM_OFF_DBG_CTRL && wstrb_q[1])
            begin
                dbg_div_q <= wdata_q[`PRM_DBG_DIV_LSB +: 8];
            end
        end
    end
    assign clk_src_o = (in_rst || !clk_ctrl_q[`PRM_CLK_EXT_BIT]) ? prm_pkg::PRM_SRC_SELF : prm_pkg::PRM_SRC_EXT; // [R01]
    assign osc_range_hi_o = clk_ctrl_q[`PRM_CLK_RANGE_BIT]; // [R03]

    // ----------------------------------------
    // Debug bit engine
    // ----------------------------------------
    logic dbg_busy_q;
    logic dbg_val_q;
    logic dbg_rx_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] div_cnt_q;
    logic dbg_tick;
    logic dbg_start;
    logic [3:0] low_len;
    assign dbg_tick = dbg_busy_q && (div_cnt_q == dbg_div_q); // [R11]
    assign dbg_start = wr_en && awaddr_q == `PRM_OFF_DBG_CTRL && wstrb_q[0]
        && wdata_q[`PRM_DBG_START_BIT] && !dbg_busy_q && !in_rst;
    assign low_len = dbg_val_q ? `PRM_BIT_LOW_ONE : `PRM_BIT_LOW_ZERO;
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            dbg_busy_q <= 1'b0;
            dbg_val_q <= 1'b0;
            dbg_rx_q <= 1'b0;
            bit_cnt_q <= 4'h0;
            div_cnt_q <= 8'h00;
        end
        else if (in_rst)
        begin
            dbg_busy_q <= 1'b0;
            bit_cnt_q <= 4'h0;
            div_cnt_q <= 8'h00;
        end
        else if (dbg_start)
        begin
            dbg_busy_q <= 1'b1;
            dbg_val_q <= wdata_q[`PRM_DBG_VAL_BIT];
            bit_cnt_q <= 4'h0;
            div_cnt_q <= 8'h00;
        end
        else if (dbg_busy_q)
        begin
            div_cnt_q <= dbg_tick ? 8'h00 : div_cnt_q + 8'h01;
            if (dbg_tick)
            begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                if (bit_cnt_q == `PRM_BIT_SAMPLE)
                begin
                    dbg_rx_q <= dbg_pin_i;
                end
                if (bit_cnt_q == `PRM_BIT_LAST)
                begin
                    dbg_busy_q <= 1'b0; // [R10]
                end
            end
        end
    end
    assign dbg_pin_oe = !in_rst && dbg_busy_q && (bit_cnt_q <= low_len); // [R07] [R12]
    assign dbg_pin_o = dbg_busy_q && (bit_cnt_q == low_len); // [R12]
    assign dbg_pullup_o = 1'b1; // [R08]

    // ----------------------------------------
    // External interrupt pin
    // ----------------------------------------
    logic irq_prev_q;
    logic irq_en;
    logic irq_rise;
    assign irq_en = irq_ctrl_q[`PRM_IRQ_EN_BIT];
    assign irq_rise = irq_ctrl_q[`PRM_IRQ_RISE_BIT];
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            irq_prev_q <= 1'b1;
            irq_req_o <= 1'b0;
        end
        else
        begin
            irq_prev_q <= irq_pin_i;
            irq_req_o <= irq_en && (irq_rise ? (irq_pin_i && !irq_prev_q) : (!irq_pin_i && irq_prev_q)); // [R13]
        end
    end
    assign irq_level_o = irq_en ? irq_pin_i : 1'b1; // [R13]
    assign irq_pull_up_o = irq_en && irq_ctrl_q[`PRM_IRQ_PULL_BIT] && !irq_rise;
    assign irq_pull_down_o = irq_en && irq_ctrl_q[`PRM_IRQ_PULL_BIT] && irq_rise; // [R18]

    // ----------------------------------------
    // Shared port pins
    // ----------------------------------------
    logic [N-1:0] own1;
    logic [N-1:0] pull_on;
    logic [N-1:0] pull_dn_sel;
    assign own1 = alt1_en_i & ~alt2_en_i; // [R19]
    assign pin_oe = (alt2_en_i & alt2_oe_i) | (own1 & alt1_oe_i) | (~alt2_en_i & ~alt1_en_i & dir_q); // [R15] [R19]
    assign pin_o = (alt2_en_i & alt2_out_i) | (own1 & alt1_out_i) | (~alt2_en_i & ~alt1_en_i & data_q); // [R19]
    assign pull_on = pull_q & ~pin_oe; // [R16]
    assign pull_dn_sel = KEYPAD_MASK & keypad_rise_i; // [R17]
    assign pull_up_o = pull_on & ~pull_dn_sel;
    assign pull_down_o = pull_on & pull_dn_sel;

    // ----------------------------------------
    // Register read
    // ----------------------------------------
    always_comb
    begin
        rd_mux = 32'h00000000;
        unique case (s_axi_araddr)
            `PRM_OFF_CLK_CTRL: rd_mux[2:0] = clk_ctrl_q;
            `PRM_OFF_RST_CAUSE: rd_mux[5:0] = cause_q;
            `PRM_OFF_MODE: rd_mux[1:0] = {!bgnd_q, bgnd_q};
            `PRM_OFF_IRQ_CTRL: rd_mux[2:0] = irq_ctrl_q;
            `PRM_OFF_PORT_DATA: rd_mux[N-1:0] = (dir_q & data_q) | (~dir_q & pin_i); // [R15]
            `PRM_OFF_PORT_DIR: rd_mux[N-1:0] = dir_q;
            `PRM_OFF_PULL_EN: rd_mux[N-1:0] = pull_q;
            `PRM_OFF_DBG_CTRL: rd_mux[15:8] = dbg_div_q;
            `PRM_OFF_DBG_STAT: rd_mux[1:0] = {dbg_rx_q, dbg_busy_q};
            default: rd_mux = 32'h00000000;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `PRM_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? `PRM_RESP_OKAY : `PRM_RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_q);
    sequence s_pulse_hold;
        ##33 rst_drive_q ##1 !rst_drive_q;
    endsequence
    sequence s_bit_hold;
        dbg_busy_q [*8] ##9 !dbg_busy_q;
    endsequence
    a_reset_pulse_len: assert property ($rose(rst_drive_q) |-> s_pulse_hold) else $error("reset pulse length"); // [R04]
    a_cause_pin_log: assert property (pulse_start && !por_pend_q && int_rst_src_i == 4'h0
        |=> cause_q == 6'h02) else $error("pin cause not logged"); // [R05]
    a_mode_bgnd_entry: assert property (rst_release && !dbg_pin_i |=> mode_o == prm_pkg::PRM_MODE_BGND && !vector_fetch_o)
        else $error("background mode not entered"); // [R09]
    a_mode_run_entry: assert property (rst_release && dbg_pin_i |=> mode_o == prm_pkg::PRM_MODE_RUN
        && vector_fetch_o && vector_addr_o == 16'hfffe) else $error("run mode vector missing"); // [R08]
    a_self_clock_rst: assert property (in_rst |-> clk_src_o == prm_pkg::PRM_SRC_SELF) else $error("clock not self"); // [R01]
    a_port_reset_state: assert property (in_rst |=> dir_q == '0 && pull_q == '0) else $error("port not reset"); // [R14]
    a_bit_time_len: assert property ($rose(dbg_busy_q) && dbg_div_q == 8'h00 |-> s_bit_hold)
        else $error("bit time wrong"); // [R10]
    a_speedup_brief: assert property (dbg_pin_o && dbg_div_q == 8'h00 |-> dbg_pin_oe ##1 !dbg_pin_o)
        else $error("speedup pulse too long"); // [R12]
    a_irq_disabled_gate: assert property (!$past(irq_en) |-> !irq_req_o) else $error("irq while disabled"); // [R13]
    a_pull_excl_dir: assert property ((pull_up_o & pull_down_o) == '0 && (pull_up_o & pin_oe) == '0)
        else $error("pull conflict"); // [R16]
    a_irq_pull_down: assert property (irq_rise |-> !irq_pull_up_o) else $error("irq pull-up on rising"); // [R18]
    a_pin_priority: assert property (alt2_en_i[N-1] |-> pin_oe[N-1] == alt2_oe_i[N-1] && pin_o[N-1] == alt2_out_i[N-1])
        else $error("priority lost"); // [R19]
endmodule
